// ===== instr_decode_pkg.sv
// shared types and constants for the instruction decoder
package instr_decode_pkg;

   localparam int WORD_W = 14;
   localparam int FILE_W = 7;
   localparam int CLKS_PER_ICYCLE = 4;
   localparam int REF_OSC_MHZ = 4;
   localparam int REF_INSTR_MHZ = REF_OSC_MHZ / CLKS_PER_ICYCLE;
   localparam logic [1:0] LAST_PHASE = 2'(CLKS_PER_ICYCLE - 1);

   // field positions
   localparam int OPC_HI = 13;
   localparam int OPC_LO = 8;
   localparam int DEST_BIT = 7;
   localparam int FILE_HI = 6;
   localparam int BITPOS_HI = 9;
   localparam int BITPOS_LO = 7;
   localparam int LIT8_HI = 7;
   localparam int LIT11_HI = 10;
   localparam int LIT9_HI = 8;
   localparam int PTRSEL_BIT = 2;
   localparam int PTRMODE_HI = 1;

   localparam logic [FILE_W-1:0] FILE_MAX = 7'h7f;

   // class prefixes on bits 13:12
   localparam logic [1:0] CLS_BYTE_PFX = 2'h0;
   localparam logic [1:0] CLS_BIT_PFX = 2'h1;

   // control opcodes
   localparam logic [13:0] OP_RETURN = 14'h0008;
   localparam logic [13:0] OP_INT_EXIT = 14'h0009;
   localparam logic [13:0] OP_CALL_ACC = 14'h000a;
   localparam logic [13:0] OP_REL_ACC = 14'h000b;
   localparam logic [2:0] OP_CALL = 3'h4;
   localparam logic [2:0] OP_ABS_JUMP = 3'h5;
   localparam logic [5:0] OP_EXIT_LIT = 6'h34;
   localparam logic [4:0] OP_REL_JUMP = 5'h19;
   localparam logic [3:0] OP_SKIP_CLR = 4'h6;
   localparam logic [3:0] OP_SKIP_SET = 4'h7;
   localparam logic [5:0] OP_DEC_SKIP = 6'h0b;
   localparam logic [5:0] OP_INC_SKIP = 6'h0f;
   localparam logic [10:0] OP_PTR_LOAD_PFX = 11'h002;
   localparam logic [10:0] OP_PTR_STORE_PFX = 11'h003;
   // bits 11:10 of bit ops that only test
   localparam logic [1:0] BIT_TEST_HI = 2'h1;

   // indirect access port addresses
   localparam logic [FILE_W-1:0] PORT0_ADDR = 7'h00;
   localparam logic [FILE_W-1:0] PORT1_ADDR = 7'h01;

   typedef enum logic [1:0] {CLASS_BYTE, CLASS_BIT, CLASS_LIT} op_class_t;
   typedef enum logic [2:0] {FLOW_SEQ, FLOW_CALL, FLOW_RET, FLOW_JUMP, FLOW_SKIP} flow_t;
   typedef enum logic [1:0] {PRE_INC, PRE_DEC, POST_INC, POST_DEC} ptr_mode_t;

   typedef struct packed {
      logic valid;
      logic [WORD_W-1:0] word;
      op_class_t opClass;
      flow_t flow;
      logic [5:0] opcode;
      logic destFile;
      logic [FILE_W-1:0] fileAddr;
      logic [2:0] bitPos;
      logic [7:0] lit8;
      logic [10:0] lit11;
      logic [8:0] relOffset;
      logic namesFile;
      logic writesFile;
      logic indirectUse;
      logic ptrSel;
      ptr_mode_t ptrMode;
   } decoded_t;

   typedef struct packed {
      logic fetch;
      logic fileRead;
      logic fileWrite;
      logic writeAccum;
      logic flush;
      logic [1:0] cycles;
   } strobes_t;

endpackage

// ===== quad_phase_gen.sv
// four-phase instruction cycle sequencer
`timescale 1ns/10ps
module quad_phase_gen
   import instr_decode_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   output logic [1:0] phase,
   output logic lastPhase
);

   typedef struct packed {
      logic [1:0] phase;
      logic lastPhase;
   } phase_state_t;

   phase_state_t st;
   phase_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.phase = (st.phase == LAST_PHASE) ? 2'h0 : st.phase + 2'h1;
      next_st.lastPhase = (next_st.phase == LAST_PHASE);
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign phase = st.phase;
   assign lastPhase = st.lastPhase;

endmodule

// ===== mcu_instr_decoder.sv
// instruction decoder and cycle timing for the 14-bit accumulator core
// Operation
// - each instruction is one 14-bit word with opcode and operands
// - opcodes fall into byte, bit, and literal/control classes
// - one cycle per instruction; both subroutine call forms take two
// - return, return with literal and interrupt exit take two cycles
// - jumps take two; skips take two only when flow changes
// - indirect access while pointer addresses program memory adds one cycle
// - an instruction cycle is four oscillator clocks
// - file register instructions always read, then store only when writesFile is set
// - destination bit zero writes accumulator, one writes file register
// - file address operand is seven bits, 0x00 to 0x7f
// - bit position selects one of eight bits
// - pointer select picks indirect pair zero or one
// - update mode picks pre/post increment/decrement
`timescale 1ns/10ps
module mcu_instr_decoder
   import instr_decode_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [WORD_W-1:0] progWord,
   input wire logic [1:0] ptrInProgMem,
   input wire logic skipCondition,
   output decoded_t decoded,
   output strobes_t strobes,
   output logic [1:0] phase
);

   typedef struct packed {
      decoded_t dec;
      logic [1:0] extraLeft;
      logic skipDone;
      strobes_t stb;
      logic [1:0] phase;
   } dec_state_t;

   dec_state_t st;
   dec_state_t next_st;
   logic [1:0] curPhase;
   logic lastPhase;

   quad_phase_gen u_phase (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .phase(curPhase),
      .lastPhase(lastPhase)
   );

   function automatic decoded_t decodeWord(input logic [WORD_W-1:0] w);
      decoded_t d;
      d = '0;
      d.valid = 1'b1;
      d.word = w;
      d.opcode = w[OPC_HI:OPC_LO];
      d.destFile = w[DEST_BIT];
      d.fileAddr = w[FILE_HI:0] & FILE_MAX;
      d.bitPos = w[BITPOS_HI:BITPOS_LO];
      d.lit8 = w[LIT8_HI:0];
      d.lit11 = w[LIT11_HI:0];
      d.relOffset = w[LIT9_HI:0];
      d.ptrSel = w[PTRSEL_BIT];
      d.ptrMode = ptr_mode_t'(w[PTRMODE_HI:0]);
      d.flow = FLOW_SEQ;
      if (w[13:12] == CLS_BYTE_PFX) begin
         d.opClass = CLASS_BYTE;
      end else if (w[13:12] == CLS_BIT_PFX) begin
         d.opClass = CLASS_BIT;
      end else begin
         d.opClass = CLASS_LIT;
      end
      // short control words live in the byte-class space with no file operand
      if (w == OP_RETURN || w == OP_INT_EXIT) begin
         d.opClass = CLASS_LIT;
         d.flow = FLOW_RET;
      end else if (w == OP_CALL_ACC) begin
         d.opClass = CLASS_LIT;
         d.flow = FLOW_CALL;
      end else if (w == OP_REL_ACC) begin
         d.opClass = CLASS_LIT;
         d.flow = FLOW_JUMP;
      end else if (w[13:3] == OP_PTR_LOAD_PFX || w[13:3] == OP_PTR_STORE_PFX) begin
         d.opClass = CLASS_LIT;
         d.indirectUse = 1'b1;
      end else if (w[13:11] == OP_CALL) begin
         d.flow = FLOW_CALL;
      end else if (w[13:11] == OP_ABS_JUMP) begin
         d.flow = FLOW_JUMP;
      end else if (w[13:8] == OP_EXIT_LIT) begin
         d.flow = FLOW_RET;
      end else if (w[13:9] == OP_REL_JUMP) begin
         d.flow = FLOW_JUMP;
      end else if (w[13:10] == OP_SKIP_CLR || w[13:10] == OP_SKIP_SET) begin
         d.flow = FLOW_SKIP;
      end else if (w[13:8] == OP_DEC_SKIP || w[13:8] == OP_INC_SKIP) begin
         d.flow = FLOW_SKIP;
      end
      d.namesFile = (d.opClass != CLASS_LIT);
      if (d.opClass == CLASS_BYTE) begin
         d.writesFile = d.destFile;
      end else if (d.opClass == CLASS_BIT) begin
         d.writesFile = (w[11:10] != BIT_TEST_HI) && (d.flow != FLOW_SKIP);
      end
      if (d.namesFile && (d.fileAddr == PORT0_ADDR || d.fileAddr == PORT1_ADDR)) begin
         d.indirectUse = 1'b1;
         d.ptrSel = d.fileAddr[0];
      end
      return d;
   endfunction

   function automatic logic [1:0] fixedExtra(input decoded_t d, input logic [1:0] inProg);
      logic [1:0] n;
      n = 2'h0;
      if (d.flow == FLOW_CALL || d.flow == FLOW_RET || d.flow == FLOW_JUMP) begin
         n = 2'h1;
      end
      if (d.indirectUse && inProg[d.ptrSel]) begin
         n = n + 2'h1;
      end
      return n;
   endfunction

   always_comb begin
      decoded_t nd;
      nd = decodeWord(progWord);
      next_st = st;
      next_st.phase = curPhase;
      next_st.stb.fetch = 1'b0;
      next_st.stb.fileRead = 1'b0;
      next_st.stb.fileWrite = 1'b0;
      if (lastPhase) begin
         // taken skip adds one flush cycle; pending extra cycles still follow
         if (st.dec.valid && st.dec.flow == FLOW_SKIP && !st.skipDone
               && skipCondition) begin
            next_st.skipDone = 1'b1;
            next_st.stb.cycles = st.stb.cycles + 2'h1;
            next_st.stb.flush = 1'b1;
         end else if (st.extraLeft != 2'h0) begin
            next_st.extraLeft = st.extraLeft - 2'h1;
            next_st.skipDone = 1'b1;
            next_st.stb.flush = 1'b1;
         end else begin
            next_st.dec = nd;
            next_st.extraLeft = fixedExtra(nd, ptrInProgMem);
            next_st.skipDone = 1'b0;
            next_st.stb.cycles = 2'h1 + fixedExtra(nd, ptrInProgMem);
            next_st.stb.flush = 1'b0;
            next_st.stb.fetch = 1'b1;
            next_st.stb.writeAccum = (nd.opClass == CLASS_BYTE) && !nd.destFile;
         end
      end else if (!st.stb.flush && st.dec.valid && st.dec.namesFile) begin
         // read in the first quarter even for write-only ops
         next_st.stb.fileRead = (curPhase == 2'h0);
         next_st.stb.fileWrite = (curPhase == 2'h2) && st.dec.writesFile;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign decoded = st.dec;
   assign strobes = st.stb;
   assign phase = st.phase;

endmodule

// ===== mcu_instr_decoder_props.sv
// concurrent checks on the decoder ports
`timescale 1ns/10ps
module mcu_instr_decoder_props
   import instr_decode_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [WORD_W-1:0] progWord,
   input wire logic [1:0] ptrInProgMem,
   input wire logic skipCondition,
   input wire decoded_t decoded,
   input wire strobes_t strobes,
   input wire logic [1:0] phase
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence quad_s;
      phase == 2'h3 ##1 phase == 2'h0 ##1 phase == 2'h1 ##1 phase == 2'h2;
   endsequence
   sequence two_s;
      !strobes.fetch [*7] ##1 strobes.fetch;
   endsequence
   property two_p(flow_t f);
      strobes.fetch && decoded.flow == f && !decoded.indirectUse |=> two_s;
   endproperty
   a_phase_walk: assert property (strobes.fetch |-> quad_s)
      else $error("phase walk broken");
   a_word_taken: assert property (strobes.fetch |-> decoded.word == $past(progWord))
      else $error("word not taken");
   a_fields_slice: assert property (decoded.valid |->
      {decoded.opcode, decoded.destFile, decoded.fileAddr} == decoded.word
      && decoded.bitPos == decoded.word[9:7]) else $error("field slice wrong");
   a_rmw_order: assert property (strobes.fetch && decoded.namesFile |->
      ##1 strobes.fileRead ##2 strobes.fileWrite == decoded.writesFile)
      else $error("read modify write order");
   a_dest_steers: assert property (strobes.fetch |->
      strobes.writeAccum == (decoded.opClass == CLASS_BYTE && !decoded.destFile))
      else $error("destination wrong");
   a_call_two: assert property (two_p(FLOW_CALL))
      else $error("call length");
   a_return_two: assert property (two_p(FLOW_RET))
      else $error("return length");
   a_skip_flush: assert property (strobes.fetch && decoded.flow == FLOW_SKIP
      ##3 skipCondition |=> strobes.flush) else $error("skip not flushed");
   a_indirect_extra: assert property (strobes.fetch && decoded.indirectUse
      && decoded.flow == FLOW_SEQ |-> strobes.cycles == 2'h1 + 2'(decoded.ptrSel ?
      $past(ptrInProgMem[1]) : $past(ptrInProgMem[0]))) else $error("indirect cost");
endmodule
bind mcu_instr_decoder mcu_instr_decoder_props chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .progWord(progWord), .ptrInProgMem(ptrInProgMem), .skipCondition(skipCondition),
   .decoded(decoded), .strobes(strobes), .phase(phase));

// ===== prog_mem_model.sv
// program memory handing one word per fetch
`timescale 1ns/10ps
module prog_mem_model
   import instr_decode_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic fetch,
   input wire logic [0:19][WORD_W-1:0] image,
   output logic [WORD_W-1:0] progWord
);
   logic [4:0] addr;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         addr <= 5'h0;
      end else if (fetch) begin
         addr <= addr + 5'h1;
      end
   end
   assign progWord = image[addr]; // whole word per instruction
endmodule

// ===== mcu_instr_decoder_bench.sv
// self-checking bench for the instruction decoder
`timescale 1ns/10ps
module mcu_instr_decoder_bench;
   import instr_decode_pkg::*;
   logic sys_clk, sys_rst, skipCondition;
   logic [1:0] ptrInProgMem, phase;
   logic [WORD_W-1:0] progWord;
   decoded_t decoded;
   strobes_t strobes;
   int err_total = 0;
   int total_checks = 0;
   logic [0:19][WORD_W-1:0] image = '{14'h07ff, 14'h0700, 14'h0701, 14'h1a92, 14'h1f85,
      14'h0ba0, 14'h0fa0, 14'h2123, 14'h2fff, 14'h0008, 14'h0009, 14'h000a, 14'h000b,
      14'h34a5, 14'h33ff, 14'h0010, 14'h0011, 14'h0012, 14'h001f, 14'h0000};
   int expCyc [0:19] = '{1, 2, 1, 2, 1, 2, 1, 2, 2, 2, 2, 2, 2, 2, 2, 1, 1, 1, 2, 1};
   logic [19:0] skipMask = 20'h00028;
   mcu_instr_decoder dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .progWord(progWord),
      .ptrInProgMem(ptrInProgMem), .skipCondition(skipCondition), .decoded(decoded),
      .strobes(strobes), .phase(phase));
   prog_mem_model mem (.sys_clk(sys_clk), .sys_rst(sys_rst), .fetch(strobes.fetch),
      .image(image), .progWord(progWord));
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wait_fetch(output int n, output logic [1:0] c);
      n = 0;
      do begin
         c = strobes.cycles;
         @(posedge sys_clk);
         #2;
         n++;
      end while (strobes.fetch !== 1'b1 && n < 20);
   endtask
   task automatic run_one(input int i);
      int n;
      logic [1:0] c;
      check(decoded.word, image[i]);
      skipCondition = skipMask[i];
      ptrInProgMem = (i < 2) ? 2'h1 : (i == 17 ? 2'h2 : 2'h0);
      wait_fetch(n, c);
      check(n, 4 * expCyc[i]);
      check(c, expCyc[i]);
   endtask
   task automatic test_byte_ops;
      check(decoded.fileAddr, 7'h7f);
      check(strobes.writeAccum, 1'b0);
      run_one(0);
      check(strobes.writeAccum, 1'b1);
      run_one(1);
      check(decoded.ptrSel, 1'b1);
      run_one(2);
      $display("done byte_ops");
   endtask
   task automatic test_skips;
      check(decoded.bitPos, 3'h5);
      check(decoded.opClass, CLASS_BIT);
      run_one(3);
      check(decoded.bitPos, 3'h7);
      for (int i = 4; i < 7; i++) begin
         run_one(i);
      end
      $display("done skips");
   endtask
   task automatic test_flow;
      flow_t f [0:7] = '{FLOW_CALL, FLOW_JUMP, FLOW_RET, FLOW_RET, FLOW_CALL, FLOW_JUMP,
         FLOW_RET, FLOW_JUMP};
      check(decoded.lit11, 11'h123);
      for (int i = 7; i < 15; i++) begin
         check(decoded.flow, f[i-7]);
         if (i == 13) begin
            check(decoded.lit8, 8'ha5);
         end
         run_one(i);
      end
      $display("done flow");
   endtask
   task automatic test_pointer;
      for (int i = 15; i < 19; i++) begin
         check(decoded.ptrMode, image[i][1:0]);
         run_one(i);
      end
      $display("done pointer");
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      #20000;
      err_total++;
      close_out();
   end
   initial begin
      int n;
      logic [1:0] c;
      sys_rst = 1'b1;
      skipCondition = 1'b0;
      ptrInProgMem = 2'h0;
      repeat (5) @(posedge sys_clk);
      #2;
      sys_rst = 1'b0;
      wait_fetch(n, c);
      test_byte_ops();
      test_skips();
      test_flow();
      test_pointer();
      close_out();
   end
endmodule
